// file: hdl/tsc_regs.sv
/*
 * Processor-status register bank of one processor tile.
 * Assumes the core drives one read or write strobe at a time on clk_in,
 * which also stands for the PLL output clock; oscillators are free-running.
 */
// Overview of operation
// - Eight-bit transmit data delay, resets zero
// - Transmit clock rises at divider, falls at half
// - Control bit routes RGMII onto peripheral ports
// - Dynamic divider acts only when threads paused
// - Divider enable bit divides PLL clock down
// - USB mode bit: one UTMI, zero ULPI
// - Bit enables ULPI hardware support module
// - Boot status read-only: number, override, core off
// - Boot flags: RAM, JTAG, skip OTP polling
// - Low boot bits show sampled PLL pins
// - Security register copies OTP security word
// - Top security bit removes write permission
// - Bits block debug, PLL JTAG, core TAP
// - Master lock plus four per-sector lock bits
// - Bit 5 OTP boot, bit 7 redundancy
// - Two enable bits start and stop oscillators
// - Oscillators run asynchronous to core clock
// - Sixteen-bit count, kept across system reset
// - Counts map tile cell, tile wire, periph cell
`timescale 1ns/1ps
module tsc_regs (
	input  wire logic                       clk_in,
	input  wire logic                       sys_rst_in,
	input  wire tsc_pkg::tsc_ps_req_t       ps_req_in,
	output logic [31:0]                     ps_rdata_out,
	output logic                            ps_ack_out,
	output logic                            ps_wr_refused_out,
	input  wire logic                       all_threads_paused_in,
	input  wire logic [7:0]                 processor_number_in,
	input  wire logic                       secure_boot_override_in,
	input  wire logic                       second_core_powered_off_in,
	input  wire logic                       otp_poll_disable_in,
	input  wire logic                       boot_from_ram_in,
	input  wire logic                       boot_from_jtag_in,
	input  wire logic [1:0]                 pll_mode_pin_in,
	input  wire logic                       otp_load_in,
	input  wire logic [31:0]                otp_word_in,
	input  wire logic [tsc_pkg::OSC_NUM-1:0] osc_clk_in,
	output logic                            rgmii_tx_clk_out,
	output logic [7:0]                      rgmii_tx_delay_out,
	output logic                            rgmii_enable_out,
	output logic                            clk_div_active_out,
	output logic                            usb_utmi_mode_out,
	output logic                            ulpi_support_enable_out,
	output logic                            global_debug_block_out,
	output logic                            pll_jtag_block_out,
	output logic                            core_jtag_block_out,
	output logic                            otp_master_lock_out,
	output logic [3:0]                      otp_sector_lock_out,
	output logic                            otp_secure_boot_out,
	output logic                            otp_redundancy_out
);
	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	tsc_pkg::tsc_feature_t feature;
	logic [31:0]           security;
	logic [1:0]            osc_enable;
	logic [1:0]            pll_pin_meta;
	logic [1:0]            pll_pin_sync;
	logic [1:0]            pll_pin_held;
	tsc_pkg::tsc_boot_t    boot;
	logic [8:0]            tx_div_count;

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	wire hit_feature  = ps_req_in.num == tsc_pkg::REG_TILE_FEATURE_CONTROL;
	wire hit_boot     = ps_req_in.num == tsc_pkg::REG_BOOT_STATUS;
	wire hit_security = ps_req_in.num == tsc_pkg::REG_OTP_PROTECTION;
	wire hit_osc_en   = ps_req_in.num == tsc_pkg::REG_FREE_OSC_ENABLE;
	wire hit_cnt0     = ps_req_in.num == tsc_pkg::REG_TILE_CELL_OSC_COUNT;
	wire hit_cnt1     = ps_req_in.num == tsc_pkg::REG_TILE_WIRE_OSC_COUNT;
	wire hit_cnt2     = ps_req_in.num == tsc_pkg::REG_PERIPH_CELL_OSC_COUNT;

	wire tsc_pkg::tsc_acc_t acc = ps_req_in.wr ? tsc_pkg::TSC_WRITE :
		(ps_req_in.rd ? tsc_pkg::TSC_READ : tsc_pkg::TSC_IDLE);

	wire wr_feature     = (acc == tsc_pkg::TSC_WRITE) && hit_feature;
	wire wr_osc_en      = (acc == tsc_pkg::TSC_WRITE) && hit_osc_en;
	wire sec_locked     = security[tsc_pkg::SEC_WRITE_LOCK_BIT];
	wire wr_security    = (acc == tsc_pkg::TSC_WRITE) && hit_security && !sec_locked;
	wire wr_sec_refused = (acc == tsc_pkg::TSC_WRITE) && hit_security && sec_locked;

	// Reserved and read-only bits keep their value on write
	wire [31:0] next_feature = (ps_req_in.wdata & tsc_pkg::FEATURE_WR_MASK) |
		(feature & ~tsc_pkg::FEATURE_WR_MASK);
	wire [31:0] next_security = ps_req_in.wdata & tsc_pkg::SECURITY_WR_MASK;
	wire [31:0] otp_copy      = otp_word_in & tsc_pkg::SECURITY_WR_MASK;

	// ---------------------------------------------------------------
	// Tile feature control
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			feature <= tsc_pkg::FEATURE_RESET;
		end else if (wr_feature) begin
			feature <= next_feature;
		end
	end

	// ---------------------------------------------------------------
	// Transmit clock generator
	// ---------------------------------------------------------------
	// Counter wraps after the divider value, so the period is value plus one
	wire       tx_wrap   = tx_div_count >= feature.rgmii_clk_div;
	wire [8:0] next_tx   = tx_wrap ? 9'h000 : tx_div_count + 9'h001;
	wire [8:0] tx_fall_at = feature.rgmii_clk_div >> 1;
	// Rise wins over fall, so a zero divider holds the clock high
	wire       tx_rise    = tx_div_count == feature.rgmii_clk_div;
	wire       tx_fall    = tx_div_count == tx_fall_at;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tx_div_count     <= 9'h000;
			rgmii_tx_clk_out <= 1'b0;
		end else begin
			tx_div_count <= next_tx;
			if (tx_rise) begin
				rgmii_tx_clk_out <= 1'b1;
			end else if (tx_fall) begin
				rgmii_tx_clk_out <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Feature outputs
	// ---------------------------------------------------------------
	// Copies lag the register by one cycle so every output is a flop
	wire next_div_active = feature.clk_div_enable &&
		(!feature.clk_div_dynamic || all_threads_paused_in);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rgmii_tx_delay_out      <= 8'h00;
			rgmii_enable_out        <= 1'b0;
			clk_div_active_out      <= 1'b0;
			usb_utmi_mode_out       <= 1'b0;
			ulpi_support_enable_out <= 1'b0;
		end else begin
			rgmii_tx_delay_out      <= feature.rgmii_tx_delay;
			rgmii_enable_out        <= feature.rgmii_enable;
			clk_div_active_out      <= next_div_active;
			usb_utmi_mode_out       <= feature.usb_utmi_mode;
			ulpi_support_enable_out <= feature.ulpi_support_enable;
		end
	end

	// ---------------------------------------------------------------
	// Boot status
	// ---------------------------------------------------------------
	// Pins are asynchronous; value is held from the end of reset onward
	// Other boot inputs share the core clock, so they need no synchroniser
	always_ff @(posedge clk_in) begin
		pll_pin_meta <= pll_mode_pin_in;
		pll_pin_sync <= pll_pin_meta;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pll_pin_held <= pll_pin_sync;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			boot <= '0;
		end else begin
			boot.rsvd_hi                 <= 8'h00;
			boot.processor_number        <= processor_number_in;
			boot.rsvd_mid                <= 7'h00;
			boot.secure_boot_override    <= secure_boot_override_in;
			boot.rsvd_lo                 <= 2'h0;
			boot.second_core_powered_off <= second_core_powered_off_in;
			boot.otp_poll_disable        <= otp_poll_disable_in;
			boot.boot_from_ram           <= boot_from_ram_in;
			boot.boot_from_jtag          <= boot_from_jtag_in;
			boot.pll_mode_pin_sample     <= pll_pin_held;
		end
	end

	// ---------------------------------------------------------------
	// Security configuration
	// ---------------------------------------------------------------
	// OTP load wins over a software write in the same cycle
	// Lock bit stops software only; an OTP load still lands
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			security <= tsc_pkg::SECURITY_RESET;
		end else if (otp_load_in) begin
			security <= otp_copy;
		end else if (wr_security) begin
			security <= next_security;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			global_debug_block_out <= 1'b0;
			pll_jtag_block_out     <= 1'b0;
			core_jtag_block_out    <= 1'b0;
			otp_master_lock_out    <= 1'b0;
			otp_sector_lock_out    <= 4'h0;
			otp_secure_boot_out    <= 1'b0;
			otp_redundancy_out     <= 1'b0;
		end else begin
			global_debug_block_out <= security[tsc_pkg::SEC_NO_GLOBAL_DEBUG];
			pll_jtag_block_out     <= security[tsc_pkg::SEC_NO_PLL_JTAG];
			core_jtag_block_out    <= security[tsc_pkg::SEC_NO_CORE_JTAG];
			otp_master_lock_out    <= security[tsc_pkg::SEC_OTP_MASTER_LOCK];
			otp_sector_lock_out    <= security[tsc_pkg::SEC_OTP_SECTOR_LSB +: 4];
			otp_secure_boot_out    <= security[tsc_pkg::SEC_SECURE_BOOT];
			otp_redundancy_out     <= security[tsc_pkg::SEC_OTP_REDUNDANCY];
		end
	end

	// ---------------------------------------------------------------
	// Oscillators
	// ---------------------------------------------------------------
	wire [1:0] next_osc_enable = ps_req_in.wdata[1:0] & tsc_pkg::OSC_EN_WR_MASK[1:0];

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			osc_enable <= tsc_pkg::OSC_EN_RESET;
		end else if (wr_osc_en) begin
			osc_enable <= next_osc_enable;
		end
	end

	// Two tile oscillators follow the core enable, the peripheral one its own
	wire [tsc_pkg::OSC_NUM-1:0] osc_run = {osc_enable[tsc_pkg::OSC_PERIPH_ENABLE_BIT],
		{2{osc_enable[tsc_pkg::OSC_CORE_ENABLE_BIT]}}};

	logic [tsc_pkg::OSC_COUNT_WIDTH-1:0] osc_count [tsc_pkg::OSC_NUM];
	logic [tsc_pkg::OSC_COUNT_WIDTH-1:0] osc_meta  [tsc_pkg::OSC_NUM];
	logic [tsc_pkg::OSC_COUNT_WIDTH-1:0] osc_sync  [tsc_pkg::OSC_NUM];

	genvar gi;
	generate
		for (gi = 0; gi < tsc_pkg::OSC_NUM; gi++) begin : g_osc
			tsc_osc_counter u_osc (
				.osc_clk_in (osc_clk_in[gi]),
				.enable_in  (osc_run[gi]),
				.count_out  (osc_count[gi])
			);

			// Count is stable once stopped, so a plain two-stage capture is safe
			// A read while an oscillator runs may catch a torn word
			always_ff @(posedge clk_in) begin
				osc_meta[gi] <= osc_count[gi];
				osc_sync[gi] <= osc_meta[gi];
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Read mux and answer
	// ---------------------------------------------------------------
	// Reserved bits of every source are forced low
	wire [31:0] rd_feature = {6'h00, feature[25:0] & tsc_pkg::FEATURE_WR_MASK[25:0]};
	wire [31:0] rd_osc_en  = {30'h0000_0000, osc_enable};
	wire [31:0] rd_count0  = {16'h0000, osc_sync[0]};
	wire [31:0] rd_count1  = {16'h0000, osc_sync[1]};
	wire [31:0] rd_count2  = {16'h0000, osc_sync[2]};
	wire        rd_taken   = acc == tsc_pkg::TSC_READ;
	wire        any_taken  = acc != tsc_pkg::TSC_IDLE;

	wire [31:0] read_mux =
		hit_feature  ? rd_feature :
		hit_boot     ? boot :
		hit_security ? security :
		hit_osc_en   ? rd_osc_en :
		hit_cnt0     ? rd_count0 :
		hit_cnt1     ? rd_count1 :
		hit_cnt2     ? rd_count2 :
		32'h0000_0000;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ps_rdata_out      <= 32'h0000_0000;
			ps_ack_out        <= 1'b0;
			ps_wr_refused_out <= 1'b0;
		end else begin
			ps_ack_out        <= any_taken;
			ps_wr_refused_out <= wr_sec_refused;
			if (rd_taken) begin
				ps_rdata_out <= read_mux;
			end
		end
	end
endmodule

// file: hdl/tsc_pkg.sv
/*
 * Constants and types for the tile status and control register bank.
 * Assumes a single core clock domain plus free-running oscillator clocks.
 */
package tsc_pkg;

	// ---------------------------------------------------------------
	// Register numbers
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_TILE_FEATURE_CONTROL  = 8'h02;
	localparam logic [7:0] REG_BOOT_STATUS           = 8'h03;
	localparam logic [7:0] REG_OTP_PROTECTION        = 8'h05;
	localparam logic [7:0] REG_FREE_OSC_ENABLE       = 8'h06;
	localparam logic [7:0] REG_TILE_CELL_OSC_COUNT   = 8'h07;
	localparam logic [7:0] REG_TILE_WIRE_OSC_COUNT   = 8'h08;
	localparam logic [7:0] REG_PERIPH_CELL_OSC_COUNT = 8'h09;

	// ---------------------------------------------------------------
	// Resource identifier form used by software
	// ---------------------------------------------------------------
	localparam int         PS_RES_SHIFT = 8;
	localparam logic [7:0] PS_RES_TYPE  = 8'h0B;

	// ---------------------------------------------------------------
	// Writable masks and reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] FEATURE_WR_MASK  = 32'h03FF_FF36;
	localparam logic [31:0] FEATURE_RESET    = 32'h0000_0000;
	localparam logic [31:0] SECURITY_WR_MASK = 32'h8000_5FB1;
	localparam logic [31:0] SECURITY_RESET   = 32'h0000_0000;
	localparam logic [31:0] OSC_EN_WR_MASK   = 32'h0000_0003;
	localparam logic [1:0]  OSC_EN_RESET     = 2'h0;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int SEC_WRITE_LOCK_BIT   = 31;
	localparam int SEC_NO_GLOBAL_DEBUG  = 14;
	localparam int SEC_OTP_MASTER_LOCK  = 12;
	localparam int SEC_OTP_SECTOR_LSB   = 8;
	localparam int SEC_OTP_REDUNDANCY   = 7;
	localparam int SEC_SECURE_BOOT      = 5;
	localparam int SEC_NO_PLL_JTAG      = 4;
	localparam int SEC_NO_CORE_JTAG     = 0;
	localparam int OSC_CORE_ENABLE_BIT  = 1;
	localparam int OSC_PERIPH_ENABLE_BIT = 0;
	localparam int OSC_COUNT_WIDTH      = 16;
	localparam int OSC_NUM              = 3;

	// ---------------------------------------------------------------
	// Field layouts
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [5:0] rsvd_hi;
		logic [7:0] rgmii_tx_delay;
		logic [8:0] rgmii_clk_div;
		logic       rgmii_enable;
		logic [1:0] rsvd_mid;
		logic       clk_div_dynamic;
		logic       clk_div_enable;
		logic       rsvd_lo;
		logic       usb_utmi_mode;
		logic       ulpi_support_enable;
		logic       rsvd_0;
	} tsc_feature_t;

	typedef struct packed {
		logic [7:0] rsvd_hi;
		logic [7:0] processor_number;
		logic [6:0] rsvd_mid;
		logic       secure_boot_override;
		logic [1:0] rsvd_lo;
		logic       second_core_powered_off;
		logic       otp_poll_disable;
		logic       boot_from_ram;
		logic       boot_from_jtag;
		logic [1:0] pll_mode_pin_sample;
	} tsc_boot_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  num;
		logic [31:0] wdata;
	} tsc_ps_req_t;

	typedef enum logic [1:0] {
		TSC_IDLE  = 2'b00,
		TSC_READ  = 2'b01,
		TSC_WRITE = 2'b10
	} tsc_acc_t;

endpackage

// file: hdl/tsc_osc_counter.sv
/*
 * One free-running oscillator with its own 16-bit counter.
 * Assumes osc_clk_in is unrelated to the core clock; enable_in is a core level.
 */
`timescale 1ns/1ps
module tsc_osc_counter (
	input  wire logic                                osc_clk_in,
	input  wire logic                                enable_in,
	output logic [tsc_pkg::OSC_COUNT_WIDTH-1:0]      count_out
);
	logic                                en_meta;
	logic                                en_sync;
	// Count is never reset by system reset; it powers up at zero
	logic [tsc_pkg::OSC_COUNT_WIDTH-1:0] count = '0;

	assign count_out = count;

	always_ff @(posedge osc_clk_in) begin
		en_meta <= enable_in;
		en_sync <= en_meta;
	end

	always_ff @(posedge osc_clk_in) begin
		if (en_sync) begin
			count <= count + 16'h0001;
		end
	end
endmodule

// file: bench/tsc_regs_properties.sv
/*
 * Checker of the register bank's processor-status port.
 * Assumes it is bound to tsc_regs and sees only that module's ports.
 */
`timescale 1ns/1ps
module tsc_regs_props (
	input  wire logic                 clk_in,
	input  wire logic                 sys_rst_in,
	input  wire tsc_pkg::tsc_ps_req_t ps_req_in,
	input  wire logic [31:0]          ps_rdata_out,
	input  wire logic                 ps_ack_out,
	input  wire logic                 ps_wr_refused_out
);
	// ---------------------------------------------------------------
	// Request decode
	// ---------------------------------------------------------------
	// Write wins when both strobes are up, so a read needs wr low
	wire logic       req_seen = ps_req_in.rd || ps_req_in.wr;
	wire logic       rd_seen  = ps_req_in.rd && !ps_req_in.wr;
	wire logic [7:0] num      = ps_req_in.num;

	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	ack_after_req_a: assert property (req_seen |=> ps_ack_out)
		else $error("no answer after a request");
	ack_needs_req_a: assert property (!req_seen |=> !ps_ack_out)
		else $error("answer without a request");
	refusal_has_ack_a: assert property (ps_wr_refused_out |-> ps_ack_out)
		else $error("refusal without answer");
	refusal_cause_a: assert property (ps_wr_refused_out |->
		$past(ps_req_in.wr) && $past(num) == tsc_pkg::REG_OTP_PROTECTION)
		else $error("refusal not caused by a security write");
	unmapped_zero_a: assert property (rd_seen && num == 8'h0A |=> ps_rdata_out == 32'h0000_0000)
		else $error("unmapped read not zero");
	feature_rsvd_a: assert property (rd_seen && num == tsc_pkg::REG_TILE_FEATURE_CONTROL |=>
		(ps_rdata_out & ~tsc_pkg::FEATURE_WR_MASK) == 32'h0000_0000)
		else $error("feature reserved bits set");
	security_rsvd_a: assert property (rd_seen && num == tsc_pkg::REG_OTP_PROTECTION |=>
		(ps_rdata_out & ~tsc_pkg::SECURITY_WR_MASK) == 32'h0000_0000)
		else $error("security reserved bits set");
	boot_rsvd_a: assert property (rd_seen && num == tsc_pkg::REG_BOOT_STATUS |=>
		ps_rdata_out[31:24] == 8'h00 && ps_rdata_out[15:9] == 7'h00 && ps_rdata_out[7:6] == 2'h0)
		else $error("boot status reserved bits set");
	count_rsvd_a: assert property (rd_seen && num inside {8'h07, 8'h08, 8'h09} |=>
		ps_rdata_out[31:16] == 16'h0000)
		else $error("count upper bits set");
	rdata_hold_a: assert property (!rd_seen |=> $stable(ps_rdata_out))
		else $error("read data moved without a read");
endmodule

bind tsc_regs tsc_regs_props tsc_regs_props_inst (
	.clk_in            (clk_in),
	.sys_rst_in        (sys_rst_in),
	.ps_req_in         (ps_req_in),
	.ps_rdata_out      (ps_rdata_out),
	.ps_ack_out        (ps_ack_out),
	.ps_wr_refused_out (ps_wr_refused_out)
);

// file: bench/test_tsc_regs.sv
/*
 * Self-checking bench of the tile status and control register bank.
 * Assumes the bound checker; the bench plays core and oscillators.
 */
`timescale 1ns/1ps
module test_tsc_regs;
	logic                 clk_in = 1'b0;
	logic                 sys_rst = 1'b1;
	tsc_pkg::tsc_ps_req_t req = '0;
	logic                 paused = 1'b0;
	logic [7:0]           pnum = 8'hA5;
	logic                 sbo = 1'b1, c1off = 1'b1, opoll = 1'b1, bram = 1'b1, bjtag = 1'b1;
	logic [1:0]           pll_pin = 2'h2;
	logic                 otp_load = 1'b0;
	logic [31:0]          otp_word = 32'h0000_0000;
	logic [2:0]           osc = 3'h0;
	logic [31:0]          rdata, v;
	logic [31:0]          cnt[3], old[3];
	logic                 ack, refused, tx_clk, div_act, utmi, ulpi, rg_en;
	logic                 gdbg, pjtag, cjtag, mlock, sboot, red;
	logic [7:0]           tx_delay;
	logic [3:0]           seclk;
	wire logic [9:0]      sec_outs = {gdbg, pjtag, cjtag, mlock, seclk, sboot, red};
	int                   mismatches = 0, checks = 0, cycles = 0;

	tsc_regs tsc_regs_inst (.clk_in(clk_in), .sys_rst_in(sys_rst), .ps_req_in(req), .ps_rdata_out(rdata),
		.ps_ack_out(ack), .ps_wr_refused_out(refused), .all_threads_paused_in(paused),
		.processor_number_in(pnum), .secure_boot_override_in(sbo), .second_core_powered_off_in(c1off),
		.otp_poll_disable_in(opoll), .boot_from_ram_in(bram), .boot_from_jtag_in(bjtag),
		.pll_mode_pin_in(pll_pin), .otp_load_in(otp_load), .otp_word_in(otp_word), .osc_clk_in(osc),
		.rgmii_tx_clk_out(tx_clk), .rgmii_tx_delay_out(tx_delay), .rgmii_enable_out(rg_en),
		.clk_div_active_out(div_act), .usb_utmi_mode_out(utmi), .ulpi_support_enable_out(ulpi),
		.global_debug_block_out(gdbg), .pll_jtag_block_out(pjtag), .core_jtag_block_out(cjtag),
		.otp_master_lock_out(mlock), .otp_sector_lock_out(seclk), .otp_secure_boot_out(sboot),
		.otp_redundancy_out(red));

	// ---------------------------------------------------------------
	// Clocks and timeout
	// ---------------------------------------------------------------
	// Oscillator rates unrelated to the core clock and to each other
	initial forever #5 clk_in = ~clk_in;
	initial forever #3.1 osc[0] = ~osc[0];
	initial forever #4.3 osc[1] = ~osc[1];
	initial forever #5.7 osc[2] = ~osc[2];
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			results();
		end
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task check_bit(input string name, input logic exp, input logic got);
		check_word(name, {31'h0, exp}, {31'h0, got});
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Write returns the refusal flag in bit 0, read returns the data
	task ps_access(input logic w, input logic [7:0] num, input logic [31:0] data, output logic [31:0] val);
		tick(1);
		req = '{!w, w, num, data};
		tick(1);
		req = '0;
		check_bit("ack", 1'b1, ack);
		val = w ? {31'h0, refused} : rdata;
	endtask
	task wr(input logic [7:0] num, input logic [31:0] data);
		ps_access(1'b1, num, data, v);
	endtask
	task rd_chk(input string name, input logic [7:0] num, input logic [31:0] exp);
		ps_access(1'b0, num, 32'h0000_0000, v);
		check_word(name, exp, v);
	endtask
	task do_reset;
		tick(1);
		sys_rst = 1'b1;
		tick(12);
		sys_rst = 1'b0;
	endtask
	task grab;
		for (int i = 0; i < 3; i++) ps_access(1'b0, 8'(7 + i), 32'h0000_0000, cnt[i]);
	endtask
	task measure(input int per, input int high);
		int n;
		int h;
		n = 0;
		while (tx_clk !== 1'b0 && n < 20) begin tick(1); n++; end
		n = 0;
		while (tx_clk !== 1'b1 && n < 20) begin tick(1); n++; end
		h = 0;
		while (tx_clk === 1'b1 && h < 20) begin tick(1); h++; end
		n = h;
		while (tx_clk !== 1'b1 && n < 20) begin tick(1); n++; end
		check_word("tx high", high, h);
		check_word("tx period", per, n);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task t_feature;
		rd_chk("feature reset", 8'h02, 32'h0000_0000);
		wr(8'h02, 32'hFFFF_FFFF);
		rd_chk("feature ones", 8'h02, tsc_pkg::FEATURE_WR_MASK);
		tick(2);
		check_word("tx delay", 32'h0000_00FF, {24'h0, tx_delay});
		check_bit("rgmii enable", 1'b1, rg_en);
		check_bit("utmi", 1'b1, utmi);
		check_bit("ulpi", 1'b1, ulpi);
		check_bit("dynamic busy", 1'b0, div_act);
		paused = 1'b1;
		tick(2);
		check_bit("dynamic paused", 1'b1, div_act);
		wr(8'h02, 32'h0000_0610);
		paused = 1'b0;
		tick(2);
		check_bit("static", 1'b1, div_act);
		check_bit("ulpi mode", 1'b0, utmi);
		measure(4, 2);
		wr(8'h02, 32'h0000_0810);
		measure(5, 3);
		wr(8'h02, 32'h0000_0000);
		tick(2);
		check_bit("divider off", 1'b0, div_act);
	endtask
	task t_boot;
		pll_pin = 2'h1;
		tick(3);
		rd_chk("boot status", 8'h03, 32'h00A5_013E);
		wr(8'h03, 32'hFFFF_FFFF);
		rd_chk("boot read only", 8'h03, 32'h00A5_013E);
		{pnum, sbo, c1off, opoll, bram, bjtag} = {8'h5A, 5'h00};
		tick(3);
		rd_chk("boot live", 8'h03, 32'h005A_0002);
	endtask
	task t_security;
		rd_chk("security reset", 8'h05, 32'h0000_0000);
		wr(8'h05, 32'h7FFF_FFFF);
		rd_chk("security ones", 8'h05, 32'h0000_5FB1);
		tick(2);
		check_word("security outs", 32'h0000_03FF, {22'h0, sec_outs});
		wr(8'h05, 32'h0000_0000);
		tick(2);
		check_word("security clear", 32'h0000_0000, {22'h0, sec_outs});
		wr(8'h05, 32'h8000_0000);
		ps_access(1'b1, 8'h05, 32'hFFFF_FFFF, v);
		check_bit("refused", 1'b1, v[0]);
		rd_chk("locked", 8'h05, 32'h8000_0000);
		otp_word = 32'h0000_1234;
		otp_load = 1'b1;
		tick(1);
		otp_load = 1'b0;
		rd_chk("otp copy", 8'h05, 32'h0000_1230);
		tick(2);
		check_word("sector lock", 32'h0000_0002, {28'h0, seclk});
		check_word("otp outs", 32'h0000_014A, {22'h0, sec_outs});
	endtask
	task t_osc;
		rd_chk("osc enable reset", 8'h06, 32'h0000_0000);
		wr(8'h06, 32'hFFFF_FFFF);
		rd_chk("osc enable ones", 8'h06, 32'h0000_0003);
		for (int m = 2; m > 0; m--) begin
			wr(8'h06, 32'h0000_0000);
			tick(20);
			grab();
			old = cnt;
			wr(8'h06, 32'(m));
			tick(60);
			wr(8'h06, 32'h0000_0000);
			tick(20);
			grab();
			for (int i = 0; i < 3; i++) check_bit("count moved", (i < 2) == (m == 2), cnt[i] !== old[i]);
		end
		old = cnt;
		do_reset();
		grab();
		for (int i = 0; i < 3; i++) check_word("count kept", old[i], cnt[i]);
		rd_chk("boot pins again", 8'h03, 32'h005A_0001);
		rd_chk("feature after reset", 8'h02, 32'h0000_0000);
		rd_chk("unmapped", 8'h0A, 32'h0000_0000);
		rd_chk("unmapped", 8'h04, 32'h0000_0000);
	endtask

	task results;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		tick(12);
		sys_rst = 1'b0;
		t_boot();
		t_feature();
		t_security();
		t_osc();
		results();
	end
endmodule
